/* common/usbl_pkg.sv */
// package: register map, field layout and link-side types of the usb endpoint block
package usbl_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_ADDR = 8'h00;
    localparam logic [7:0] OFF_CR0  = 8'h04;
    localparam logic [7:0] OFF_CR3  = 8'h10;
    localparam logic [7:0] OFF_IEN  = 8'h14;
    localparam logic [7:0] OFF_IFL  = 8'h18;
    localparam logic [7:0] OFF_SR0  = 8'h1c;
    localparam logic [7:0] OFF_SR2  = 8'h20;
    localparam logic [7:0] OFF_OPT  = 8'h24;
    localparam logic [7:0] OFF_BUF  = 8'h40;
    localparam logic [7:0] OFF_BEND = 8'hbc;
    localparam logic [7:0] CR_STEP  = 8'h04;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int B_ON    = 7;
    localparam int B_TGL   = 7;
    localparam int B_TXON  = 6;
    localparam int B_RXON  = 4;
    localparam int B_EP1   = 0;
    localparam int B_EP2   = 1;
    localparam int B_EP2IN = 2;
    localparam int B_PULL  = 3;
    localparam int I_CTX   = 0;
    localparam int I_CRX   = 1;
    localparam int I_E1TX  = 2;
    localparam int I_E2    = 3;
    localparam int I_EOP   = 4;
    localparam int I_RST   = 5;
    localparam int B_SETUP = 6;
    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam logic [15:0] IRQ_VECTOR = 16'hfffa;
    localparam logic [3:0]  MAX_LEN    = 4'h8;
    localparam logic [6:0]  DEF_ADDR   = 7'h00;
    localparam logic [1:0]  EP_CTL     = 2'h0;
    localparam logic [1:0]  EP_ONE     = 2'h1;
    localparam logic [1:0]  EP_TWO     = 2'h2;
    localparam logic [1:0]  BUF_E0RX   = 2'h0;
    localparam logic [1:0]  BUF_E0TX   = 2'h1;
    localparam logic [1:0]  BUF_E1     = 2'h2;
    localparam logic [1:0]  BUF_E2     = 2'h3;
    localparam int          CLK_NS     = 8;
    localparam int          BUSRST_NS  = 2500;
    localparam int          BUSRST_CYC = (BUSRST_NS + CLK_NS - 1) / CLK_NS;
    // ------------------------------------------------------------
    // link types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {PID_SETUP, PID_OUT, PID_IN} usbl_pid_type;
    typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_DATA0, HS_DATA1} usbl_hs_type;
    typedef struct packed {
        logic         valid;
        usbl_pid_type pid;
        logic [6:0]   addr;
        logic [1:0]   ep;
    } usbl_tok_type;
    typedef struct packed {
        logic       valid;
        logic       eop;
        logic [7:0] data;
    } usbl_rx_type;
    typedef struct packed {
        logic        valid;
        usbl_hs_type kind;
        logic [3:0]  len;
    } usbl_resp_type;
    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } usbl_tx_type;
endpackage

/* hdl/usbl_ep_ctrl.sv */
// usb low-speed endpoint control: apb registers, endpoint buffers, token handling
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module usbl_ep_ctrl
    import usbl_pkg::*;
#(
    parameter int BUSRST_CYCLES = BUSRST_CYC
)(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire usbl_tok_type  tok,
    input  wire usbl_rx_type   rx,
    input  wire logic          host_ack,
    input  wire logic          bus_eop,
    input  wire logic          se0_pin,
    input  wire logic          tx_ready,
    output usbl_resp_type      resp,
    output usbl_tx_type        tx,
    output logic               usb_irq,
    output logic               chip_reset_req,
    output logic               pullup_en
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (BUSRST_CYCLES < 2 || BUSRST_CYCLES > 511) begin : g_chk
        $error("BUSRST_CYCLES out of range");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX, ST_ACKW} usbl_st_type;

    logic [7:0]    addr_r;
    logic [7:0]    ctl_r [0:2];
    logic [3:0]    cr3_r;
    logic [4:0]    ien_r;
    logic [5:0]    ifl_r;
    logic [7:0]    sr0_r;
    logic [3:0]    sr2_r;
    logic          opt_r;
    logic          opt_done_r;
    logic [7:0]    mem_r [0:31];
    logic [31:0]   prdata_r;
    logic          se0_s1_r;
    logic          se0_s2_r;
    logic [8:0]    rst_cnt_r;
    logic          chip_rst_r;
    logic          irq_r;
    usbl_st_type   st_r;
    logic [1:0]    cur_ep_r;
    logic [1:0]    cur_buf_r;
    logic          cur_setup_r;
    logic          acc_r;
    logic [3:0]    cnt_r;
    logic [3:0]    len_r;
    usbl_resp_type resp_r;
    usbl_tx_type   tx_r;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire        wr_en    = psel & penable & pwrite;
    wire        setup_ph = psel & ~penable;
    wire        in_buf   = (paddr >= OFF_BUF) && (paddr <= OFF_BEND) && (paddr[1:0] == 2'h0);
    wire [4:0]  bidx     = 5'((paddr - OFF_BUF) >> 2);
    wire        is_cr    = (paddr == OFF_CR0) || (paddr == OFF_CR0 + CR_STEP)
                        || (paddr == OFF_CR0 + 2 * CR_STEP);
    wire [1:0]  cr_idx   = 2'((paddr - OFF_CR0) >> 2);
    wire        mapped   = in_buf || is_cr || paddr == OFF_ADDR || paddr == OFF_CR3
                        || paddr == OFF_IEN || paddr == OFF_IFL || paddr == OFF_SR0
                        || paddr == OFF_SR2 || paddr == OFF_OPT;
    wire [7:0]  cr_val   = (cr_idx == EP_ONE) ? ctl_r[1] : (cr_idx == EP_TWO) ? ctl_r[2] : ctl_r[0];
    wire [7:0]  rd_byte  = in_buf               ? mem_r[bidx]
                         : is_cr                ? cr_val
                         : (paddr == OFF_ADDR)  ? addr_r
                         : (paddr == OFF_CR3)   ? 8'(cr3_r)
                         : (paddr == OFF_IEN)   ? 8'(ien_r)
                         : (paddr == OFF_IFL)   ? 8'(ifl_r)
                         : (paddr == OFF_SR0)   ? sr0_r
                         : (paddr == OFF_SR2)   ? 8'(sr2_r)
                         : (paddr == OFF_OPT)   ? 8'(opt_r)
                         : 8'h00;

    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ------------------------------------------------------------
    // bus reset detection
    // ------------------------------------------------------------
    wire bus_rst_p   = se0_s2_r && (rst_cnt_r == 9'(BUSRST_CYCLES - 1));
    wire bus_rst_irq = bus_rst_p & opt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            se0_s1_r  <= 1'b0;
            se0_s2_r  <= 1'b0;
            rst_cnt_r <= 9'h000;
        end else begin
            se0_s1_r  <= se0_pin;
            se0_s2_r  <= se0_s1_r;
            if (!se0_s2_r)
                rst_cnt_r <= 9'h000;
            else if (rst_cnt_r != 9'(BUSRST_CYCLES))
                rst_cnt_r <= rst_cnt_r + 9'h001;
        end
    end

    // ------------------------------------------------------------
    // token decode
    // ------------------------------------------------------------
    wire [1:0] tep    = tok.ep;
    wire       is_in  = tok.pid == PID_IN;
    wire       ep_on  = (tep == EP_CTL)
                     || (tep == EP_ONE && cr3_r[B_EP1])
                     || (tep == EP_TWO && cr3_r[B_EP2]);
    wire       dir_ok = (tep == EP_CTL) ? 1'b1
                      : (tok.pid == PID_SETUP) ? 1'b0
                      : (tep == EP_ONE) ? is_in
                      : (is_in == cr3_r[B_EP2IN]);
    wire       adr_ok = tok.addr == addr_r[6:0];
    wire       hit    = tok.valid && addr_r[B_ON] && adr_ok && ep_on && dir_ok
                     && st_r == ST_IDLE;
    wire [7:0] tctl   = (tep == EP_ONE) ? ctl_r[1] : (tep == EP_TWO) ? ctl_r[2] : ctl_r[0];
    wire [3:0] tlen   = (tctl[3:0] > MAX_LEN) ? MAX_LEN : tctl[3:0];
    wire [1:0] tbuf   = (tep == EP_CTL) ? (is_in ? BUF_E0TX : BUF_E0RX)
                      : (tep == EP_ONE) ? BUF_E1 : BUF_E2;
    wire       in_nak = hit && is_in && !tctl[B_TXON];

    // ------------------------------------------------------------
    // transaction events
    // ------------------------------------------------------------
    wire       rx_take = (st_r == ST_RX) && rx.valid && acc_r && (cnt_r < MAX_LEN);
    wire [3:0] rx_cnt  = cnt_r + 4'(rx_take);
    wire       rx_ok   = (st_r == ST_RX) && rx.eop && acc_r;
    wire       tx_done = (st_r == ST_ACKW) && host_ack;
    wire       eop_ev  = bus_eop & ien_r[I_EOP];
    wire [5:0] ifl_set = {bus_rst_irq,
                          eop_ev,
                          (rx_ok | tx_done) && cur_ep_r == EP_TWO,
                          tx_done && cur_ep_r == EP_ONE,
                          rx_ok && cur_ep_r == EP_CTL,
                          tx_done && cur_ep_r == EP_CTL};
    wire       wr_ifl  = wr_en && paddr == OFF_IFL;
    wire [5:0] ifl_clr = wr_ifl ? pwdata[5:0] : 6'h00;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_r     <= 8'h00;
            cr3_r      <= 4'h0;
            ien_r      <= 5'h00;
            ifl_r      <= 6'h00;
            sr0_r      <= 8'h00;
            sr2_r      <= 4'h0;
            opt_r      <= 1'b0;
            opt_done_r <= 1'b0;
            prdata_r   <= 32'h0000_0000;
            chip_rst_r <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            if (setup_ph)
                prdata_r <= 32'(rd_byte);
            ifl_r <= (ifl_r & ~ifl_clr) | ifl_set;
            irq_r <= |(ifl_r[4:0] & ien_r) | ifl_r[I_RST];
            if (wr_en && paddr == OFF_IEN)
                ien_r <= pwdata[4:0];
            if (wr_en && paddr == OFF_OPT && !opt_done_r) begin
                opt_r      <= pwdata[0];
                opt_done_r <= 1'b1;
            end
            if (bus_rst_p && !opt_r)
                chip_rst_r <= 1'b1;
            if (bus_rst_irq)
                addr_r[6:0] <= DEF_ADDR;
            else if (wr_en && paddr == OFF_ADDR)
                addr_r <= pwdata[7:0];
            if (bus_rst_irq) begin
                cr3_r[B_EP1] <= 1'b0;
                cr3_r[B_EP2] <= 1'b0;
            end else if (wr_en && paddr == OFF_CR3)
                cr3_r <= pwdata[3:0];
            if (rx_ok && cur_ep_r == EP_CTL)
                sr0_r <= 8'({cur_setup_r, 6'(rx_cnt)} << (B_SETUP - 6));
            if (rx_ok && cur_ep_r == EP_TWO)
                sr2_r <= rx_cnt;
        end
    end

    // per-endpoint control registers; software arming wins over hardware disarm
    for (genvar i = 0; i < 3; i++) begin : g_ctl
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctl_r[i] <= 8'h00;
            end else if (wr_en && is_cr && cr_idx == 2'(i)) begin
                ctl_r[i] <= pwdata[7:0];
            end else begin
                if (tx_done && cur_ep_r == 2'(i))
                    ctl_r[i][B_TXON] <= 1'b0;
                if (rx_ok && cur_ep_r == 2'(i))
                    ctl_r[i][B_RXON] <= 1'b0;
            end
        end
    end

    // endpoint buffers
    always_ff @(posedge pclk) begin
        if (wr_en && in_buf)
            mem_r[bidx] <= pwdata[7:0];
        if (rx_take)
            mem_r[{cur_buf_r, cnt_r[2:0]}] <= rx.data;
    end

    // ------------------------------------------------------------
    // transaction state machine
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r        <= ST_IDLE;
            cur_ep_r    <= EP_CTL;
            cur_buf_r   <= BUF_E0RX;
            cur_setup_r <= 1'b0;
            acc_r       <= 1'b0;
            cnt_r       <= 4'h0;
            len_r       <= 4'h0;
            resp_r      <= '0;
            tx_r        <= '0;
        end else begin
            resp_r <= '0;
            if (bus_rst_p) begin
                st_r <= ST_IDLE;
                tx_r <= '0;
            end else begin
                case (st_r)
                    ST_IDLE: begin
                        if (hit) begin
                            cur_ep_r    <= tep;
                            cur_buf_r   <= tbuf;
                            cur_setup_r <= tok.pid == PID_SETUP;
                            cnt_r       <= 4'h0;
                            if (!is_in) begin
                                acc_r <= tctl[B_RXON];
                                st_r  <= ST_RX;
                            end else if (in_nak) begin
                                resp_r <= '{1'b1, HS_NAK, 4'h0};
                            end else begin
                                resp_r <= '{1'b1, tctl[B_TGL] ? HS_DATA1 : HS_DATA0, tlen};
                                len_r  <= tlen;
                                if (tlen == 4'h0) begin
                                    st_r <= ST_ACKW;
                                end else begin
                                    st_r <= ST_TX;
                                    tx_r <= '{1'b1, tlen == 4'h1, mem_r[{tbuf, 3'h0}]};
                                end
                            end
                        end
                    end
                    ST_RX: begin
                        cnt_r <= rx_cnt;
                        if (rx.eop) begin
                            resp_r <= '{1'b1, acc_r ? HS_ACK : HS_NAK, 4'h0};
                            st_r   <= ST_IDLE;
                        end
                    end
                    ST_TX: begin
                        if (tx_ready) begin
                            if (tx_r.last) begin
                                tx_r <= '0;
                                st_r <= ST_ACKW;
                            end else begin
                                cnt_r <= cnt_r + 4'h1;
                                tx_r  <= '{1'b1, 4'(cnt_r + 4'h2) == len_r,
                                           mem_r[{cur_buf_r, 3'(cnt_r + 4'h1)}]};
                            end
                        end
                    end
                    ST_ACKW: begin
                        if (host_ack || tok.valid)
                            st_r <= ST_IDLE;
                    end
                    default: st_r <= ST_IDLE;
                endcase
            end
        end
    end

    assign resp           = resp_r;
    assign tx             = tx_r;
    assign usb_irq        = irq_r;
    assign chip_reset_req = chip_rst_r;
    assign pullup_en      = cr3_r[B_PULL];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_nak_when_empty: assert property (in_nak |=> resp.valid && resp.kind == HS_NAK)
        else $error("in token without data not answered with nak");
    a_module_off_quiet: assert property (tok.valid && !addr_r[B_ON] && st_r == ST_IDLE
        |=> !resp.valid [*2])
        else $error("response while module off");
    a_addr_filter: assert property (tok.valid && !adr_ok && st_r == ST_IDLE
        |=> !resp.valid && st_r == ST_IDLE)
        else $error("token for another address answered");
    a_setup_status: assert property (rx_ok && cur_ep_r == EP_CTL && cur_setup_r
        && rx_cnt == MAX_LEN |=> sr0_r == 8'h48 && ifl_r[I_CRX])
        else $error("setup status not 0x48");
    a_out_clears_setup: assert property (rx_ok && cur_ep_r == EP_CTL && !cur_setup_r
        |=> !sr0_r[B_SETUP] && ifl_r[I_CRX])
        else $error("out reception left setup indicator set");
    a_rx_gate: assert property (st_r == ST_RX && rx.eop && !acc_r
        |=> resp.kind == HS_NAK && $stable(ifl_r[I_CRX]))
        else $error("data accepted with receive off");
    a_opt_write_once: assert property (wr_en && paddr == OFF_OPT && opt_done_r
        |=> $stable(opt_r))
        else $error("option register written twice");
    a_bus_rst_irq: assert property (bus_rst_irq |=> addr_r[6:0] == DEF_ADDR
        && !cr3_r[B_EP1] && !cr3_r[B_EP2] && ifl_r[I_RST] ##1 usb_irq)
        else $error("bus reset interrupt effects missing");
    a_bus_rst_chip: assert property (bus_rst_p && !opt_r |=> chip_reset_req)
        else $error("bus reset did not request chip reset");
    a_zero_len_ack: assert property (hit && is_in && tctl[B_TXON] && tlen == 4'h0
        |=> resp.len == 4'h0 && st_r == ST_ACKW && !tx.valid)
        else $error("zero length packet sent data");
    a_eop_gated: assert property (bus_eop && !ien_r[I_EOP] && !ifl_r[I_EOP]
        && !(wr_ifl && pwdata[I_EOP]) |=> !ifl_r[I_EOP])
        else $error("eop flag set while disabled");

    c_setup_rx: cover property (rx_ok && cur_setup_r && rx_cnt == MAX_LEN);
    c_in_data: cover property (tx_r.valid && tx_r.last && tx_ready);
    c_in_nak: cover property (in_nak);
    c_bus_rst: cover property (bus_rst_irq);
endmodule

/* tb/usbl_host.sv */
// host side model: tokens, data packets, handshakes and bus reset
`timescale 1ns/1ns
module usbl_host
    import usbl_pkg::*;
(
    input  wire logic    pclk,
    output usbl_tok_type tok,
    output usbl_rx_type  rx,
    output logic         host_ack,
    output logic         bus_eop,
    output logic         se0_pin,
    output logic         tx_ready
);
    int seed = 32'hf2f8;
    logic [7:0] sent [0:7];
    initial begin
        tok = '0;
        rx = '0;
        {host_ack, bus_eop, se0_pin} = 3'h0;
    end
    always @(posedge pclk) tx_ready <= ($random(seed) & 3) != 0;
    task send_tok(input usbl_pid_type p, input logic [6:0] a, input logic [1:0] e);
        @(posedge pclk) tok <= '{1'b1, p, a, e};
        @(posedge pclk) tok <= '{1'b0, p, ~a, ~e};
    endtask
    task send_pkt(input int n);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            sent[i] = d;
            @(posedge pclk) rx <= '{1'b1, i == n - 1, d};
            bus_eop <= i == n - 1;
        end
        if (n == 0) begin
            @(posedge pclk) rx <= '{1'b0, 1'b1, 8'h5a};
            bus_eop <= 1'b1;
        end
        @(posedge pclk) rx <= '{1'b0, 1'b0, ~rx.data};
        bus_eop <= 1'b0;
    endtask
    task ack();
        @(posedge pclk) host_ack <= 1'b1;
        @(posedge pclk) host_ack <= 1'b0;
    endtask
    task bus_rst(input int n);
        @(posedge pclk) se0_pin <= 1'b1;
        repeat (n) @(posedge pclk);
        se0_pin <= 1'b0;
    endtask
endmodule

/* tb/tb.sv */
// testbench: register access and host traffic against the endpoint block
`timescale 1ns/1ns
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t %s", $time, m); end end
module tb;
    import usbl_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv;
    logic pready, pslverr, slv, usb_irq, chip_reset_req, pullup_en;
    logic host_ack, bus_eop, se0_pin, tx_ready;
    usbl_tok_type tok;
    usbl_rx_type rx;
    usbl_resp_type resp, last;
    usbl_tx_type tx;
    int miscompares = 0, num_checks = 0, n_resp = 0, base, n, seed = 32'hf2f8;
    int ntx = 0, tx0;
    logic [7:0] txb [0:7], exp_tx [0:7];
    always #4 pclk = ~pclk;
    usbl_ep_ctrl #(.BUSRST_CYCLES(8)) dut(.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .tok, .rx, .host_ack, .bus_eop,
        .se0_pin, .tx_ready, .resp, .tx, .usb_irq, .chip_reset_req, .pullup_en);
    usbl_host host(.pclk, .tok, .rx, .host_ack, .bus_eop, .se0_pin, .tx_ready);
    always @(posedge pclk) if (resp.valid === 1'b1) begin
        last <= resp;
        n_resp <= n_resp + 1;
    end
    always @(posedge pclk) if (tx.valid === 1'b1 && tx_ready === 1'b1) begin
        txb[ntx[2:0]] <= tx.data;
        ntx <= ntx + 1;
    end
    function logic [7:0] exp_sr0(input logic setup, input int cnt);
        return {1'b0, setup, 2'b00, 4'(cnt)};
    endfunction
    task results();
        if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 40);
        if (k >= 40) begin miscompares++; results(); end
        rdv = prdata;
        slv = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, d); endtask
    task rd(input logic [7:0] a); apb(0, a, 0); endtask
    task tk(input usbl_pid_type p, input logic [6:0] a, input logic [1:0] e);
        base = n_resp;
        host.send_tok(p, a, e);
    endtask
    task expr(input usbl_hs_type h, input logic [3:0] l);
        int k;
        k = 0;
        while (n_resp == base && k < 40) begin @(posedge pclk); k++; end
        if (k >= 40) begin miscompares++; results(); end
        `CHK(last.kind, h, "handshake kind")
        if (h >= HS_DATA0) `CHK(last.len, l, "data length")
    endtask
    task none();
        repeat (20) @(posedge pclk);
        `CHK(n_resp, base, "unexpected handshake")
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        rd(OFF_ADDR);
        `CHK(rdv, 32'h0, "address reset value")
        rd(8'h3c);
        `CHK(slv, 1'b1, "unmapped slot")
        tk(PID_IN, DEF_ADDR, EP_CTL);
        none();
        wr(OFF_ADDR, 32'h80);
        tk(PID_IN, DEF_ADDR, EP_CTL);
        expr(HS_NAK, 0);
        tk(PID_SETUP, DEF_ADDR, EP_CTL);
        host.send_pkt(8);
        expr(HS_NAK, 0);
        rd(OFF_IFL);
        `CHK(rdv, 32'h0, "masked flags")
        wr(OFF_IEN, 32'h1f);
        for (int i = 0; i < 2; i++) begin
            n = i ? {$random(seed)} % 9 : 8;
            wr(OFF_CR0, 32'h10);
            tk(i ? PID_OUT : PID_SETUP, DEF_ADDR, EP_CTL);
            host.send_pkt(n);
            expr(HS_ACK, 0);
            rd(OFF_SR0);
            `CHK(rdv[7:0], exp_sr0(i == 0, n), "status zero")
            for (int j = 0; j < n; j++) begin
                rd(OFF_BUF + 8'({BUF_E0RX, 3'(j), 2'b00}));
                `CHK(rdv[7:0], host.sent[j], "received byte")
            end
            rd(OFF_IFL);
            `CHK(rdv[5:0], 6'h12, "receive and eop flags")
            `CHK(usb_irq, 1'b1, "irq raised")
            wr(OFF_IFL, 32'h3f);
            rd(OFF_IFL);
            `CHK(usb_irq, 1'b0, "irq cleared")
        end
        for (int t = 0; t < 2; t++) begin
            n = t ? 0 : 1 + {$random(seed)} % 8;
            for (int j = 0; j < n; j++) begin
                exp_tx[j] = 8'($random(seed));
                wr(OFF_BUF + 8'({BUF_E0TX, 3'(j), 2'b00}), 32'(exp_tx[j]));
            end
            wr(OFF_CR0, (t << B_TGL) | 32'h40 | n);
            tx0 = ntx;
            tk(PID_IN, DEF_ADDR, EP_CTL);
            expr(t ? HS_DATA1 : HS_DATA0, 4'(n));
            for (int k = 0; k < 200 && tx.valid === 1'b1; k++) @(posedge pclk);
            `CHK(tx.valid, 1'b0, "transmit stream stalled")
            host.ack();
            `CHK(ntx - tx0, n, "transmit byte count")
            for (int j = 0; j < n; j++) `CHK(txb[3'(tx0 + j)], exp_tx[j], "transmit byte")
            rd(OFF_IFL);
            `CHK(rdv[0], 1'b1, "transmit flag")
            wr(OFF_IFL, 32'h3f);
            tk(PID_IN, DEF_ADDR, EP_CTL);
            expr(HS_NAK, 0);
        end
        n = 1 + {$random(seed)} % 127;
        wr(OFF_ADDR, 32'h80 | n);
        tk(PID_IN, DEF_ADDR, EP_CTL);
        none();
        tk(PID_IN, 7'(n), EP_ONE);
        none();
        wr(OFF_CR3, 32'h0b);
        @(posedge pclk);
        `CHK(pullup_en, 1'b1, "pull-up on")
        tk(PID_IN, 7'(n), EP_ONE);
        expr(HS_NAK, 0);
        tk(PID_IN, 7'(n), EP_TWO);
        none();
        wr(OFF_CR0 + 8'(2 * CR_STEP), 32'h10);
        tk(PID_OUT, 7'(n), EP_TWO);
        host.send_pkt(3);
        expr(HS_ACK, 0);
        rd(OFF_SR2);
        `CHK(rdv[3:0], 4'h3, "endpoint two count")
        tk(PID_IN, 7'(n), 2'h3);
        none();
        wr(OFF_CR3, 32'h0f);
        tk(PID_IN, 7'(n), EP_TWO);
        expr(HS_NAK, 0);
        wr(OFF_OPT, 32'h1);
        wr(OFF_OPT, 32'h0);
        rd(OFF_OPT);
        `CHK(rdv[0], 1'b1, "option written once")
        host.bus_rst(12);
        repeat (6) @(posedge pclk);
        `CHK(chip_reset_req, 1'b0, "no chip reset")
        rd(OFF_IFL);
        `CHK(rdv[5], 1'b1, "bus reset flag")
        rd(OFF_CR3);
        `CHK(rdv[1:0], 2'b00, "endpoints off")
        tk(PID_IN, DEF_ADDR, EP_CTL);
        expr(HS_NAK, 0);
        presetn <= 0;
        @(posedge pclk) presetn <= 1;
        wr(OFF_ADDR, 32'h80);
        host.bus_rst(12);
        repeat (6) @(posedge pclk);
        `CHK(chip_reset_req, 1'b1, "chip reset")
        results();
    end
endmodule
